// ### tcu_pkg.sv
/*
 * Package for the 8-bit timer/counter with one compare channel: register
 * offsets, field positions, reset values, mode encodings and carrier types.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package tcu_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] TCU_OFF_CONTROL = 8'h00;
    localparam logic [7:0] TCU_OFF_COUNT = 8'h04;
    localparam logic [7:0] TCU_OFF_COMPARE = 8'h08;
    localparam logic [7:0] TCU_OFF_FLAGS = 8'h0C;
    localparam logic [7:0] TCU_OFF_MASK = 8'h10;
    localparam logic [7:0] TCU_OFF_ASYNC = 8'h14;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TCU_CTL_CS_LSB = 0;
    localparam int TCU_CTL_WGM_LSB = 3;
    localparam int TCU_CTL_COM_LSB = 5;
    localparam int TCU_CTL_FOC_BIT = 7;
    localparam int TCU_FLG_OVF_BIT = 0;
    localparam int TCU_FLG_CMP_BIT = 1;
    localparam int TCU_ASY_SEL_BIT = 0;

    // ****************************************
    // reset values and extremes
    // ****************************************
    localparam logic [7:0] TCU_RST_BYTE = 8'h00;
    localparam logic [7:0] TCU_BOTTOM = 8'h00;
    localparam logic [7:0] TCU_MAX = 8'hFF;
    localparam logic [31:0] TCU_RD_UNMAPPED = 32'h0000_0000;

    // waveform mode encodings
    localparam logic [1:0] TCU_WGM_NORMAL = 2'h0;
    localparam logic [1:0] TCU_WGM_PHASE = 2'h1;
    localparam logic [1:0] TCU_WGM_CTC = 2'h2;
    localparam logic [1:0] TCU_WGM_FAST = 2'h3;

    // output action encodings
    localparam logic [1:0] TCU_COM_OFF = 2'h0;
    localparam logic [1:0] TCU_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TCU_COM_CLEAR = 2'h2;
    localparam logic [1:0] TCU_COM_SET = 2'h3;

    // control register fields
    typedef struct packed {
        logic forceCompare;
        logic [1:0] outputAction;
        logic [1:0] waveformMode;
        logic [2:0] clockSelect;
    } tcu_ctrl_t;

    // ticks towards the counter
    typedef struct packed {
        logic ioTick;
        logic xtalTick;
    } tcu_ticks_t;

endpackage

// ### tcu_prescaler.sv
/*
 * Tick source for the counter: divides the system clock by the selected
 * prescale factor; with asyncSelect, synchronised crystal-edge ticks pass only on a divider rollover, every one at factor 1.
 * Assumes xtalRise is already synchronised to clk, one pulse per edge.
 */
`timescale 1ns/10ps
module tcu_prescaler
    import tcu_pkg::*;
#(
    parameter int DIV_BITS = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // selection
    input wire logic [2:0] clockSelect,
    input wire logic asyncSelect,
    input wire logic xtalRise,
    // tick out
    output logic tick
);

    // the widest factor needs ten divider bits
    if (DIV_BITS < 10) begin : g_bad_width
        $error("tcu_prescaler: DIV_BITS must be at least 10");
    end

    logic [DIV_BITS-1:0] divCount;

    always_ff @(posedge clk) begin
        if (rst) begin
            divCount <= '0;
        end else begin
            divCount <= divCount + 1'b1;
        end
    end

    // factor 1,8,32,64,128,256,1024: tick when the low bits roll over
    function automatic logic rollover(input logic [DIV_BITS-1:0] c, input int bits);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 10; i++) begin
            if (i < bits && !c[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    always_comb begin
        case (clockSelect)
            3'd0: tick = 1'b0;
            3'd1: tick = asyncSelect ? xtalRise : 1'b1;
            3'd2: tick = rollover(divCount, 3) & (asyncSelect ? xtalRise : 1'b1);
            3'd3: tick = rollover(divCount, 5) & (asyncSelect ? xtalRise : 1'b1);
            3'd4: tick = rollover(divCount, 6) & (asyncSelect ? xtalRise : 1'b1);
            3'd5: tick = rollover(divCount, 7) & (asyncSelect ? xtalRise : 1'b1);
            3'd6: tick = rollover(divCount, 8) & (asyncSelect ? xtalRise : 1'b1);
            3'd7: tick = rollover(divCount, 10) & (asyncSelect ? xtalRise : 1'b1);
            default: tick = 1'b0;
        endcase
    end

endmodule // tcu_prescaler

// ### tcu_timer.sv
/*
 * 8-bit timer/counter with one compare unit behind an APB slave.
 * Assumes APB master on clk; crystal pin is asynchronous and synchronised here.
 */
`timescale 1ns/10ps
module tcu_timer
    import tcu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // crystal oscillator pins
    input wire logic crystal_pin_in,
    output logic crystal_pin_out,
    // port pin shared with the compare output
    input wire logic portValue,
    output logic compare_output,
    output logic pinValue,
    // interrupt service
    input wire logic compareIrqAck,
    input wire logic overflowIrqAck,
    output logic compareIrq,
    output logic overflowIrq
);

    // ****************************************
    // registers
    // ****************************************
    tcu_ctrl_t timer_control_reg;
    logic [7:0] count_value, compare_value, compareBuffer;
    logic [1:0] timer_flag_reg, timer_mask_reg;
    logic async_clock_select, countingDown, blockNext, tick;
    logic xtalSync1, xtalSync2, xtalPrev;

    // ****************************************
    // bus decode
    // ****************************************
    logic wrEn, rdEn;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    logic wrControl, wrCount, wrCompare, wrFlags;
    assign wrControl = wrEn && paddr == TCU_OFF_CONTROL;
    assign wrCount = wrEn && paddr == TCU_OFF_COUNT;
    assign wrCompare = wrEn && paddr == TCU_OFF_COMPARE;
    assign wrFlags = wrEn && paddr == TCU_OFF_FLAGS;
    logic [1:0] mode, action;
    logic pwm;
    assign mode = timer_control_reg.waveformMode;
    assign action = timer_control_reg.outputAction;
    assign pwm = mode == TCU_WGM_PHASE || mode == TCU_WGM_FAST;

    // ****************************************
    // tick source
    // ****************************************
    // crystal pin is asynchronous; only the second stage and its delayed copy are read
    always_ff @(posedge clk) begin
        if (rst) begin
            xtalSync1 <= 1'b0;
            xtalSync2 <= 1'b0;
            xtalPrev <= 1'b0;
        end else begin
            xtalSync1 <= crystal_pin_in;
            xtalSync2 <= xtalSync1;
            xtalPrev <= xtalSync2;
        end
    end
    assign crystal_pin_out = ~xtalSync2;

    tcu_prescaler #(
        .DIV_BITS(10)
    ) u_prescaler (
        .clk(clk),
        .rst(rst),
        .clockSelect(timer_control_reg.clockSelect),
        .asyncSelect(async_clock_select),
        .xtalRise(xtalSync2 && !xtalPrev),
        .tick(tick)
    );

    // ****************************************
    // counter state decode
    // ****************************************
    logic atBottom, atMax, rawMatch, match, loadPoint;
    logic [7:0] topValue;
    assign atBottom = count_value == TCU_BOTTOM;
    assign atMax = count_value == TCU_MAX;
    assign topValue = (mode == TCU_WGM_CTC) ? compare_value : TCU_MAX;
    assign rawMatch = count_value == compare_value;
    assign match = rawMatch && !blockNext;

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            count_value <= TCU_RST_BYTE;
        end else if (wrCount) begin
            count_value <= pwdata[7:0];
        end else if (tick) begin
            case (mode)
                TCU_WGM_NORMAL: count_value <= count_value + 8'h01;
                TCU_WGM_CTC: count_value <= match ? TCU_BOTTOM : count_value + 8'h01;
                TCU_WGM_FAST: count_value <= atMax ? TCU_BOTTOM : count_value + 8'h01;
                TCU_WGM_PHASE: begin
                    if (countingDown) begin
                        count_value <= count_value - 8'h01;
                    end else begin
                        count_value <= count_value + 8'h01;
                    end
                end
                default: count_value <= count_value;
            endcase
        end
    end

    // direction for phase-correct: turn at top and bottom
    logic next_countingDown;
    always_comb begin
        next_countingDown = countingDown;
        if (mode != TCU_WGM_PHASE) begin
            next_countingDown = 1'b0;
        end else if (!countingDown && count_value == 8'hFE) begin
            next_countingDown = 1'b1;
        end else if (countingDown && count_value == 8'h01) begin
            next_countingDown = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            countingDown <= 1'b0;
        end else if (tick && !wrCount) begin
            countingDown <= next_countingDown;
        end
    end

    // write blocks matches until the next tick has passed, even if stopped
    always_ff @(posedge clk) begin
        if (rst) begin
            blockNext <= 1'b0;
        end else if (wrCount) begin
            blockNext <= 1'b1;
        end else if (tick) begin
            blockNext <= 1'b0;
        end
    end

    // ****************************************
    // compare register with double buffer
    // ****************************************
    assign loadPoint = tick && count_value == topValue;

    always_ff @(posedge clk) begin
        if (rst) begin
            compareBuffer <= TCU_RST_BYTE;
        end else if (wrCompare) begin
            compareBuffer <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            compare_value <= TCU_RST_BYTE;
        end else if (wrCompare && !pwm) begin
            compare_value <= pwdata[7:0];
        end else if (pwm && loadPoint) begin
            compare_value <= compareBuffer;
        end
    end

    // ****************************************
    // flags, mask and async select
    // ****************************************
    logic overflowEvent, compareEvent;
    always_comb begin
        overflowEvent = 1'b0;
        if (tick && !wrCount) begin
            case (mode)
                TCU_WGM_PHASE: overflowEvent = countingDown && count_value == 8'h01;
                default: overflowEvent = atMax;
            endcase
        end
    end
    assign compareEvent = tick && match;

    // set beats clear
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_flag_reg <= 2'b00;
        end else begin
            timer_flag_reg[TCU_FLG_OVF_BIT] <= overflowEvent ||
                (timer_flag_reg[TCU_FLG_OVF_BIT] && !overflowIrqAck &&
                 !(wrFlags && pwdata[TCU_FLG_OVF_BIT]));
            timer_flag_reg[TCU_FLG_CMP_BIT] <= compareEvent ||
                (timer_flag_reg[TCU_FLG_CMP_BIT] && !compareIrqAck &&
                 !(wrFlags && pwdata[TCU_FLG_CMP_BIT]));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timer_mask_reg <= 2'b00;
        end else if (wrEn && paddr == TCU_OFF_MASK) begin
            timer_mask_reg <= pwdata[1:0];
        end
    end

    assign overflowIrq = timer_flag_reg[TCU_FLG_OVF_BIT] && timer_mask_reg[TCU_FLG_OVF_BIT];
    assign compareIrq = timer_flag_reg[TCU_FLG_CMP_BIT] && timer_mask_reg[TCU_FLG_CMP_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            async_clock_select <= 1'b0;
        end else if (wrEn && paddr == TCU_OFF_ASYNC) begin
            async_clock_select <= pwdata[TCU_ASY_SEL_BIT];
        end
    end

    // force strobe is never stored: reads back as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_control_reg <= '0;
        end else if (wrControl) begin
            timer_control_reg <= tcu_ctrl_t'({1'b0, pwdata[6:0]});
        end
    end

    // ****************************************
    // waveform generator
    // ****************************************
    logic ocState, forceNow;
    assign forceNow = wrControl && pwdata[TCU_CTL_FOC_BIT] && !pwm;

    // applies the action field using the live setting, not a buffered one
    function automatic logic applyAction(input logic [1:0] act, input logic cur);
        case (act)
            TCU_COM_TOGGLE: return !cur;
            TCU_COM_CLEAR: return 1'b0;
            TCU_COM_SET: return 1'b1;
            default: return cur;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            ocState <= 1'b0;
        end else if (forceNow) begin
            ocState <= applyAction(pwdata[TCU_CTL_COM_LSB +: 2], ocState);
        end else if (compareEvent && !pwm) begin
            ocState <= applyAction(action, ocState);
        end else if (tick && mode == TCU_WGM_FAST && action[1]) begin
            if (match) begin
                ocState <= action[0];
            end else if (atMax) begin
                ocState <= !action[0];
            end
        end else if (compareEvent && mode == TCU_WGM_PHASE && action[1]) begin
            ocState <= countingDown ? !action[0] : action[0];
        end
        // mode changes leave ocState untouched
    end

    assign compare_output = ocState;
    assign pinValue = (action != TCU_COM_OFF) ? ocState : portValue;

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        prdata = TCU_RD_UNMAPPED;
        if (rdEn) begin
            case (paddr)
                TCU_OFF_CONTROL: prdata = {24'h00_0000, timer_control_reg};
                TCU_OFF_COUNT: prdata = {24'h00_0000, count_value};
                TCU_OFF_COMPARE: prdata = {24'h00_0000, pwm ? compareBuffer : compare_value};
                TCU_OFF_FLAGS: prdata = {30'h0000_0000, timer_flag_reg};
                TCU_OFF_MASK: prdata = {30'h0000_0000, timer_mask_reg};
                TCU_OFF_ASYNC: prdata = {31'h0000_0000, async_clock_select};
                default: prdata = TCU_RD_UNMAPPED;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_write_priority: assert property (@(posedge clk) disable iff (rst)
        wrCount |=> count_value == $past(pwdata[7:0]))
        else $error("count write lost");
    a_stop_holds: assert property (@(posedge clk) disable iff (rst)
        timer_control_reg.clockSelect == 3'd0 && !wrCount |=> $stable(count_value))
        else $error("counter moved while stopped");
    a_match_flag: assert property (@(posedge clk) disable iff (rst)
        tick && rawMatch && !blockNext |=> timer_flag_reg[TCU_FLG_CMP_BIT])
        else $error("compare flag missed");
    a_write_blocks: assert property (@(posedge clk) disable iff (rst)
        wrCount ##1 (tick && !wrCount && !timer_flag_reg[TCU_FLG_CMP_BIT] && !compareIrqAck)
        |=> !timer_flag_reg[TCU_FLG_CMP_BIT])
        else $error("match not blocked after count write");
    a_flag_clear: assert property (@(posedge clk) disable iff (rst)
        wrFlags && pwdata[TCU_FLG_CMP_BIT] && !compareEvent |=> !timer_flag_reg[TCU_FLG_CMP_BIT])
        else $error("compare flag not cleared");
    a_normal_wrap: assert property (@(posedge clk) disable iff (rst)
        tick && !wrCount && mode == TCU_WGM_NORMAL && atMax
        |=> count_value == TCU_BOTTOM && timer_flag_reg[TCU_FLG_OVF_BIT])
        else $error("normal wrap or overflow wrong");
    a_ctc_clear: assert property (@(posedge clk) disable iff (rst)
        tick && !wrCount && mode == TCU_WGM_CTC && match |=> count_value == TCU_BOTTOM)
        else $error("clear on match failed");
    a_force_noflag: assert property (@(posedge clk) disable iff (rst)
        forceNow && !compareEvent && !timer_flag_reg[TCU_FLG_CMP_BIT]
        |=> !timer_flag_reg[TCU_FLG_CMP_BIT])
        else $error("force set the flag");
    a_buffer_hold: assert property (@(posedge clk) disable iff (rst)
        pwm && !loadPoint && $stable(mode) |=> $stable(compare_value))
        else $error("compare loaded outside top");
    a_pin_mux: assert property (@(posedge clk) disable iff (rst)
        action != TCU_COM_OFF |-> pinValue == ocState)
        else $error("pin not handed to waveform");

    c_overflow: cover property (@(posedge clk) overflowEvent);
    c_force: cover property (@(posedge clk) forceNow);
    c_phase_turn: cover property (@(posedge clk) tick && countingDown && mode == TCU_WGM_PHASE);
    c_match_blocked: cover property (@(posedge clk) tick && rawMatch && blockNext);
    c_fast_bottom: cover property (@(posedge clk) tick && atBottom && mode == TCU_WGM_FAST);

endmodule // tcu_timer

// ### testbench.sv
/*
 * Self-checking bench for the 8-bit timer/counter with one compare channel.
 * Assumes the zero-wait APB slave of tcu_timer and a tick every clock at /1.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module testbench
    import tcu_pkg::*;
;
    logic clk, rst, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, saved;
    logic pready, pslverr, xtalIn, xtalOut, portValue, cmpOut, pinValue;
    logic cmpAck, ovfAck, cmpIrq, ovfIrq;
    logic [1:0] acts [3];
    logic expOut [3];
    int n_mismatch, total_checks;

    tcu_timer i_tcu_timer (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystal_pin_in(xtalIn),
        .crystal_pin_out(xtalOut), .portValue(portValue), .compare_output(cmpOut),
        .pinValue(pinValue), .compareIrqAck(cmpAck), .overflowIrqAck(ovfAck),
        .compareIrq(cmpIrq), .overflowIrq(ovfIrq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************
    // bus access
    // ****************************************
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, ex, rdata)
    endtask

    function automatic logic [31:0] ctl(logic f, logic [1:0] com, logic [1:0] wgm,
            logic [2:0] cs);
        return {24'h00_0000, f, com, wgm, cs};
    endfunction

    task endtest(input string nm);
        $display("test %s done", nm);
    endtask

    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; xtalIn = 1'b0;
        portValue = 1'b0; cmpAck = 1'b0; ovfAck = 1'b0;
        acts = '{TCU_COM_SET, TCU_COM_CLEAR, TCU_COM_TOGGLE};
        expOut = '{1'b1, 1'b0, 1'b1};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(TCU_OFF_CONTROL, 32'h0000_0000, "control");
        rdchk(TCU_OFF_COUNT, 32'h0000_0000, "count");
        rdchk(TCU_OFF_FLAGS, 32'h0000_0000, "flags");
        rdchk(8'h18, 32'h0000_0000, "unmapped");
        `CHK("slave error", 1'b0, pslverr)
        wr(TCU_OFF_COUNT, 32'h0000_005A);
        repeat (20) @(posedge clk);
        rdchk(TCU_OFF_COUNT, 32'h0000_005A, "stopped count");
        endtest("reset and stop");
        // overflow: wrap from max with compare kept out of reach
        wr(TCU_OFF_MASK, 32'h0000_0001);
        wr(TCU_OFF_COMPARE, 32'h0000_0080);
        wr(TCU_OFF_COUNT, 32'h0000_00F0);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h1));
        repeat (30) @(posedge clk);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h0));
        rdchk(TCU_OFF_FLAGS, 32'h0000_0001, "overflow flag");
        `CHK("overflow irq", 1'b1, ovfIrq)
        ovfAck <= 1'b1;
        @(posedge clk);
        ovfAck <= 1'b0;
        @(posedge clk);
        `CHK("overflow irq cleared", 1'b0, ovfIrq)
        endtest("overflow");
        wr(TCU_OFF_MASK, 32'h0000_0002);
        wr(TCU_OFF_COMPARE, 32'h0000_0010);
        wr(TCU_OFF_COUNT, 32'h0000_0000);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h1));
        repeat (30) @(posedge clk);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h0));
        rdchk(TCU_OFF_FLAGS, 32'h0000_0002, "compare flag");
        `CHK("compare irq", 1'b1, cmpIrq)
        cmpAck <= 1'b1;
        @(posedge clk);
        cmpAck <= 1'b0;
        @(posedge clk);
        rdchk(TCU_OFF_FLAGS, 32'h0000_0000, "compare serviced");
        // counter parked on the compare value: the write must hide that match
        wr(TCU_OFF_COMPARE, 32'h0000_0005);
        wr(TCU_OFF_COUNT, 32'h0000_0005);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h1));
        repeat (20) @(posedge clk);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h0));
        rdchk(TCU_OFF_FLAGS, 32'h0000_0000, "blocked match");
        endtest("compare");
        wr(TCU_OFF_COMPARE, 32'h0000_0003);
        wr(TCU_OFF_COUNT, 32'h0000_0000);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_CTC, 3'h1));
        repeat (25) @(posedge clk);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_CTC, 3'h0));
        apb(1'b0, TCU_OFF_COUNT, 32'h0000_0000);
        `CHK("ctc top", 1'b1, rdata <= 32'h0000_0003)
        saved = rdata;
        rdchk(TCU_OFF_FLAGS, 32'h0000_0002, "ctc flags");
        wr(TCU_OFF_FLAGS, 32'h0000_0002);
        rdchk(TCU_OFF_FLAGS, 32'h0000_0000, "write one clears");
        endtest("clear on match");
        portValue <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(TCU_OFF_CONTROL, ctl(1'b1, acts[i], TCU_WGM_NORMAL, 3'h0));
            `CHK("forced output", expOut[i], cmpOut)
            `CHK("pin value", expOut[i], pinValue)
        end
        rdchk(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_TOGGLE, TCU_WGM_NORMAL, 3'h0), "strobe");
        rdchk(TCU_OFF_FLAGS, 32'h0000_0000, "forced no flag");
        rdchk(TCU_OFF_COUNT, saved, "forced no reload");
        portValue <= 1'b0;
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_FAST, 3'h0));
        `CHK("output kept", 1'b1, cmpOut)
        `CHK("port routed", 1'b0, pinValue)
        endtest("force");
        // crystal edges only: no system clock ticks may reach the counter
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h0));
        wr(TCU_OFF_COUNT, 32'h0000_0000);
        wr(TCU_OFF_ASYNC, 32'h0000_0001);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h1));
        repeat (10) begin
            xtalIn <= 1'b1;
            repeat (4) @(posedge clk);
            xtalIn <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        rdchk(TCU_OFF_COUNT, 32'h0000_000A, "crystal count");
        `CHK("crystal drive back", 1'b1, xtalOut)
        endtest("crystal");
        // phase-correct then fast PWM, both with the buffered compare
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_OFF, TCU_WGM_NORMAL, 3'h0));
        wr(TCU_OFF_ASYNC, 32'h0000_0000);
        wr(TCU_OFF_COMPARE, 32'h0000_0020);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_PHASE, 3'h0));
        wr(TCU_OFF_COMPARE, 32'h0000_0040);
        rdchk(TCU_OFF_COMPARE, 32'h0000_0040, "compare buffer");
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_NORMAL, 3'h0));
        rdchk(TCU_OFF_COMPARE, 32'h0000_0020, "active compare held");
        wr(TCU_OFF_COUNT, 32'h0000_00F8);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_PHASE, 3'h1));
        repeat (17) @(posedge clk);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_PHASE, 3'h0));
        // twenty ticks: seven up to top, thirteen down
        rdchk(TCU_OFF_COUNT, 32'h0000_00F2, "phase count");
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_NORMAL, 3'h0));
        rdchk(TCU_OFF_COMPARE, 32'h0000_0040, "buffer loaded at top");
        endtest("phase correct");
        wr(TCU_OFF_FLAGS, 32'h0000_0003);
        wr(TCU_OFF_CONTROL, ctl(1'b1, TCU_COM_CLEAR, TCU_WGM_NORMAL, 3'h0));
        `CHK("forced clear", 1'b0, cmpOut)
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_FAST, 3'h0));
        wr(TCU_OFF_COUNT, 32'h0000_00FC);
        wr(TCU_OFF_COMPARE, 32'h0000_0008);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_FAST, 3'h1));
        repeat (3) @(posedge clk);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_FAST, 3'h0));
        `CHK("set at bottom", 1'b1, pinValue)
        rdchk(TCU_OFF_FLAGS, 32'h0000_0001, "fast overflow");
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_FAST, 3'h1));
        repeat (5) @(posedge clk);
        wr(TCU_OFF_CONTROL, ctl(1'b0, TCU_COM_CLEAR, TCU_WGM_FAST, 3'h0));
        `CHK("clear on match", 1'b0, cmpOut)
        rdchk(TCU_OFF_COUNT, 32'h0000_000A, "fast count");
        rdchk(TCU_OFF_FLAGS, 32'h0000_0003, "fast flags");
        endtest("pwm");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end
endmodule // testbench
